// ---- rtl/sar_adc_control.sv ----
// successive approximation converter control with an ahb-lite register slave
// assumes the analog array settles within one conversion clock after dac_code changes
// and that compare_in is high when the sampled input is at or above dac_code
//
// Summary of operation
// - reserved channels convert silently, no error
// - temperature code routes the on-chip sensor
// - four conversion clock sources selectable
// - selected source divided by divide field
// - alternate clock keeps running in wait
// - hardware trigger on counter equals modulo
// - trigger independent of counter interrupt enable
// - trigger delivered in run, wait, stop3
// - pin enables only for channels 0-15
// - linear twelve-bit successive approximation
// - right-justified twelve, ten or eight bits
// - single or continuous; single returns idle
// - optional less-than or greater-equal compare
// - done flag and gated interrupt request
// - configurable sample time and power setting
// - all-ones channel powers down, stops conversions
// - control-one write aborts; restarts unless hardware trigger selected
// - done flag clears on control-one write or result read
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module sar_adc_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] rtc_counter_value,
  input wire logic [7:0] rtc_modulo_value,
  input wire logic local_async_clock,
  input wire logic alternate_clock_input,
  input wire logic sar_compare_in,
  output logic [11:0] sar_dac_code,
  output logic sar_sample,
  output logic sar_enable,
  output logic sar_power_down,
  output logic sar_low_power,
  output logic [4:0] sar_channel,
  output logic temp_sensor_enable,
  output logic [15:0] analog_pin_enable,
  output logic conv_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adc_ctrl_pkg::conv_state_e state_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic bus_take;
  logic write_one;
  logic read_result;
  logic int_en_q;
  logic cont_q;
  logic [4:0] chan_q;
  logic hwtrg_q;
  logic cmp_en_q;
  logic cmp_ge_q;
  logic [11:0] cmp_val_q;
  logic lowpow_q;
  logic [1:0] div_q;
  logic long_q;
  logic [1:0] mode_q;
  logic [1:0] src_q;
  logic done_q;
  logic done_set;
  logic [11:0] result_q;
  logic [11:0] formatted;
  logic [11:0] sar_q;
  logic [3:0] bit_idx_q;
  logic [3:0] bit_next;
  logic [4:0] samp_cnt_q;
  logic [4:0] samp_last;
  logic [2:0] settle_q;
  logic settled;
  logic [1:0] cmp_sync_q;
  logic rtc_match_q;
  logic rtc_match_prev_q;
  logic trig_pulse;
  logic tick;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] format_result(input logic [11:0] raw, input logic [1:0] mode);
    case (mode)
      adc_ctrl_pkg::MODE_10: format_result = {2'h0, raw[11:2]};
      adc_ctrl_pkg::MODE_8: format_result = {4'h0, raw[11:4]};
      default: format_result = raw;
    endcase
  endfunction

  function automatic logic compare_true(input logic [11:0] res, input logic [11:0] val, input logic ge);
    compare_true = ge ? (res >= val) : (res < val);
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave: writes take no wait state, reads take one
  // ----------------------------------------------------------------
  assign bus_take = hsel && hready && htrans[1];
  assign write_one = wr_pend_q && (addr_q == adc_ctrl_pkg::ADDR_CONV_ONE);
  assign read_result = rd_pend_q && (addr_q == adc_ctrl_pkg::ADDR_RESULT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= bus_take && hwrite;
      rd_pend_q <= bus_take && !hwrite;
      hreadyout <= !(bus_take && !hwrite);
      hresp <= 1'b0;
      if (bus_take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // the read wait state lets a write in the previous data phase land before the mux is sampled
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      adc_ctrl_pkg::ADDR_CONV_ONE: begin
        rd_mux[adc_ctrl_pkg::ONE_DONE_BIT] = done_q;
        rd_mux[adc_ctrl_pkg::ONE_INT_EN_BIT] = int_en_q;
        rd_mux[adc_ctrl_pkg::ONE_CONT_BIT] = cont_q;
        rd_mux[4:0] = chan_q;
      end
      adc_ctrl_pkg::ADDR_CONV_TWO: begin
        rd_mux[adc_ctrl_pkg::TWO_ACTIVE_BIT] = (state_q != adc_ctrl_pkg::ST_IDLE);
        rd_mux[adc_ctrl_pkg::TWO_HWTRG_BIT] = hwtrg_q;
        rd_mux[adc_ctrl_pkg::TWO_CMP_EN_BIT] = cmp_en_q;
        rd_mux[adc_ctrl_pkg::TWO_CMP_GE_BIT] = cmp_ge_q;
      end
      adc_ctrl_pkg::ADDR_RESULT: rd_mux[11:0] = result_q;
      adc_ctrl_pkg::ADDR_COMPARE: rd_mux[11:0] = cmp_val_q;
      adc_ctrl_pkg::ADDR_CONFIG: rd_mux[7:0] = {lowpow_q, div_q, long_q, mode_q, src_q};
      adc_ctrl_pkg::ADDR_PIN_CTRL: rd_mux[15:0] = analog_pin_enable;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_en_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= adc_ctrl_pkg::CHAN_RESET;
      hwtrg_q <= 1'b0;
      cmp_en_q <= 1'b0;
      cmp_ge_q <= 1'b0;
      cmp_val_q <= 12'h000;
      lowpow_q <= 1'b0;
      div_q <= 2'h0;
      long_q <= 1'b0;
      mode_q <= adc_ctrl_pkg::MODE_8;
      src_q <= adc_ctrl_pkg::SRC_BUS;
      analog_pin_enable <= 16'h0000;
    end else if (wr_pend_q) begin
      case (addr_q)
        adc_ctrl_pkg::ADDR_CONV_ONE: begin
          int_en_q <= hwdata[adc_ctrl_pkg::ONE_INT_EN_BIT];
          cont_q <= hwdata[adc_ctrl_pkg::ONE_CONT_BIT];
          chan_q <= hwdata[4:0];
        end
        adc_ctrl_pkg::ADDR_CONV_TWO: begin
          hwtrg_q <= hwdata[adc_ctrl_pkg::TWO_HWTRG_BIT];
          cmp_en_q <= hwdata[adc_ctrl_pkg::TWO_CMP_EN_BIT];
          cmp_ge_q <= hwdata[adc_ctrl_pkg::TWO_CMP_GE_BIT];
        end
        adc_ctrl_pkg::ADDR_COMPARE: cmp_val_q <= hwdata[11:0];
        adc_ctrl_pkg::ADDR_CONFIG: begin
          lowpow_q <= hwdata[adc_ctrl_pkg::CFG_LOWPOW_BIT];
          div_q <= hwdata[adc_ctrl_pkg::CFG_DIV_LSB +: 2];
          long_q <= hwdata[adc_ctrl_pkg::CFG_LONG_BIT];
          mode_q <= hwdata[adc_ctrl_pkg::CFG_MODE_LSB +: 2];
          src_q <= hwdata[adc_ctrl_pkg::CFG_SRC_LSB +: 2];
        end
        // channels above 15 have no pin enable, so only sixteen bits exist
        adc_ctrl_pkg::ADDR_PIN_CTRL: analog_pin_enable <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // hardware trigger from the real-time counter
  // ----------------------------------------------------------------
  // no interrupt enable or low-power state gates the match, so it fires in run, wait and stop3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtc_match_q <= 1'b0;
      rtc_match_prev_q <= 1'b0;
    end else begin
      rtc_match_q <= (rtc_counter_value == rtc_modulo_value);
      rtc_match_prev_q <= rtc_match_q;
    end
  end

  assign trig_pulse = rtc_match_q && !rtc_match_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_sync_q <= 2'h0;
    end else begin
      cmp_sync_q <= {cmp_sync_q[0], sar_compare_in};
    end
  end

  conv_clock_gen u_clock_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .src_sel(src_q),
    .div_sel(div_q),
    .run(state_q != adc_ctrl_pkg::ST_IDLE),
    .local_async_clock(local_async_clock),
    .alternate_clock_input(alternate_clock_input),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  assign samp_last = (long_q ? adc_ctrl_pkg::SAMPLE_LONG_TICKS : adc_ctrl_pkg::SAMPLE_SHORT_TICKS) - 5'h01;
  assign bit_next = bit_idx_q - 4'h1;
  assign formatted = format_result(sar_q, mode_q);

  // a bit is judged only once its trial code has come back through the comparator path,
  // so a bus-rate conversion clock stretches each bit rather than reading a stale compare
  assign settled = (settle_q == adc_ctrl_pkg::SETTLE_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= 3'h0;
    end else if (state_q != adc_ctrl_pkg::ST_CONVERT || write_one || (tick && settled)) begin
      settle_q <= 3'h0;
    end else if (!settled) begin
      settle_q <= settle_q + 3'h1;
    end
  end

  // reserved codes are converted like any other channel; the result is simply undefined
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= adc_ctrl_pkg::ST_IDLE;
      samp_cnt_q <= 5'h00;
      bit_idx_q <= 4'h0;
      sar_q <= 12'h000;
    end else if (write_one) begin
      samp_cnt_q <= 5'h00;
      if (hwdata[4:0] == adc_ctrl_pkg::CHAN_DISABLED) begin
        state_q <= adc_ctrl_pkg::ST_IDLE;
      end else if (!hwtrg_q) begin
        state_q <= adc_ctrl_pkg::ST_SAMPLE;
      end else begin
        state_q <= adc_ctrl_pkg::ST_IDLE;
      end
    end else if (trig_pulse && hwtrg_q && state_q == adc_ctrl_pkg::ST_IDLE &&
                 chan_q != adc_ctrl_pkg::CHAN_DISABLED) begin
      state_q <= adc_ctrl_pkg::ST_SAMPLE;
      samp_cnt_q <= 5'h00;
    end else if (tick) begin
      case (state_q)
        adc_ctrl_pkg::ST_SAMPLE: begin
          samp_cnt_q <= samp_cnt_q + 5'h01;
          if (samp_cnt_q == samp_last) begin
            state_q <= adc_ctrl_pkg::ST_CONVERT;
            bit_idx_q <= adc_ctrl_pkg::MSB_INDEX;
            sar_q <= adc_ctrl_pkg::MSB_TRIAL;
          end
        end
        adc_ctrl_pkg::ST_CONVERT: begin
          if (settled) begin
            sar_q[bit_idx_q] <= cmp_sync_q[1];
            if (bit_idx_q == 4'h0) begin
              state_q <= adc_ctrl_pkg::ST_FINISH;
            end else begin
              sar_q[bit_next] <= 1'b1;
              bit_idx_q <= bit_next;
            end
          end
        end
        adc_ctrl_pkg::ST_FINISH: begin
          samp_cnt_q <= 5'h00;
          if (cont_q && chan_q != adc_ctrl_pkg::CHAN_DISABLED) begin
            state_q <= adc_ctrl_pkg::ST_SAMPLE;
          end else begin
            state_q <= adc_ctrl_pkg::ST_IDLE;
          end
        end
        default: state_q <= adc_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result, completion flag and request
  // ----------------------------------------------------------------
  assign done_set = tick && !write_one && (state_q == adc_ctrl_pkg::ST_FINISH) &&
                    (!cmp_en_q || compare_true(formatted, cmp_val_q, cmp_ge_q));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 12'h000;
    end else if (done_set) begin
      result_q <= formatted;
    end
  end

  // a completion landing with a result read keeps the flag set; a control-one write suppresses the completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (write_one || read_result) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= done_q && int_en_q;
    end
  end

  // ----------------------------------------------------------------
  // analog side controls
  // ----------------------------------------------------------------
  // the bandgap code needs the buffer enabled elsewhere first; nothing here checks it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sar_dac_code <= 12'h000;
      sar_sample <= 1'b0;
      sar_enable <= 1'b0;
      sar_power_down <= 1'b1;
      sar_low_power <= 1'b0;
      sar_channel <= adc_ctrl_pkg::CHAN_RESET;
      temp_sensor_enable <= 1'b0;
    end else begin
      sar_dac_code <= sar_q;
      sar_sample <= (state_q == adc_ctrl_pkg::ST_SAMPLE);
      sar_enable <= (state_q != adc_ctrl_pkg::ST_IDLE);
      sar_power_down <= (chan_q == adc_ctrl_pkg::CHAN_DISABLED);
      sar_low_power <= lowpow_q;
      sar_channel <= chan_q;
      temp_sensor_enable <= (chan_q == adc_ctrl_pkg::CHAN_TEMP) &&
                            (state_q != adc_ctrl_pkg::ST_IDLE);
    end
  end

endmodule

// ---- rtl/adc_ctrl_pkg.sv ----
// constants, register map and state encoding of the converter control block
// assumes a 32-bit ahb-lite register bus and one bus clock
package adc_ctrl_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV_ONE = 8'h00;
  localparam logic [7:0] ADDR_CONV_TWO = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_COMPARE = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ONE_DONE_BIT = 7;
  localparam int ONE_INT_EN_BIT = 6;
  localparam int ONE_CONT_BIT = 5;
  localparam int TWO_ACTIVE_BIT = 7;
  localparam int TWO_HWTRG_BIT = 6;
  localparam int TWO_CMP_EN_BIT = 5;
  localparam int TWO_CMP_GE_BIT = 4;
  localparam int CFG_LOWPOW_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_BIT = 4;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_SRC_LSB = 0;

  // ----------------------------------------------------------------
  // channel codes, formats, clock sources
  // ----------------------------------------------------------------
  localparam logic [4:0] CHAN_TEMP = 5'h1a;
  localparam logic [4:0] CHAN_BANDGAP = 5'h1b;
  localparam logic [4:0] CHAN_DISABLED = 5'h1f;
  localparam logic [4:0] CHAN_RESET = 5'h1f;

  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;

  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;

  // ----------------------------------------------------------------
  // sizes and timing counts in conversion clock ticks, except the settle count in hclk cycles
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 12;
  localparam int PIN_CTRL_BITS = 16;
  localparam logic [4:0] SAMPLE_SHORT_TICKS = 5'h04;
  localparam logic [4:0] SAMPLE_LONG_TICKS = 5'h14;
  localparam logic [3:0] MSB_INDEX = 4'hb;
  localparam logic [11:0] MSB_TRIAL = 12'h800;
  // hclk cycles a trial code needs through the dac register, the comparator and its synchroniser
  localparam logic [2:0] SETTLE_LAST = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11,
    ST_FINISH = 2'b10
  } conv_state_e;

endpackage

// ---- rtl/conv_clock_gen.sv ----
// conversion clock enable: picks one of four sources and divides it
// assumes the alternate and local asynchronous clocks arrive as pins that are slower than half of hclk
`timescale 1ns/1ps
module conv_clock_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] src_sel,
  input wire logic [1:0] div_sel,
  input wire logic run,
  input wire logic local_async_clock,
  input wire logic alternate_clock_input,
  output logic tick
);

  // ----------------------------------------------------------------
  // synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] async_sync_q;
  logic [2:0] alt_sync_q;
  logic half_q;
  logic src_pulse;
  logic [2:0] div_cnt_q;
  logic [2:0] div_last;

  // the alternate clock is never gated by low-power state, so it keeps counting in wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      async_sync_q <= 3'h0;
      alt_sync_q <= 3'h0;
    end else begin
      async_sync_q <= {async_sync_q[1:0], local_async_clock};
      alt_sync_q <= {alt_sync_q[1:0], alternate_clock_input};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  always_comb begin
    case (src_sel)
      adc_ctrl_pkg::SRC_BUS: src_pulse = 1'b1;
      adc_ctrl_pkg::SRC_BUS_HALF: src_pulse = half_q;
      adc_ctrl_pkg::SRC_ALT: src_pulse = alt_sync_q[1] & ~alt_sync_q[2];
      adc_ctrl_pkg::SRC_ASYNC: src_pulse = async_sync_q[1] & ~async_sync_q[2];
      default: src_pulse = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // divide by 1, 2, 4 or 8
  // ----------------------------------------------------------------
  always_comb begin
    case (div_sel)
      2'h0: div_last = 3'h0;
      2'h1: div_last = 3'h1;
      2'h2: div_last = 3'h3;
      default: div_last = 3'h7;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 3'h0;
      tick <= 1'b0;
    end else if (!run) begin
      div_cnt_q <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= src_pulse && (div_cnt_q == div_last);
      if (src_pulse) begin
        div_cnt_q <= (div_cnt_q == div_last) ? 3'h0 : div_cnt_q + 3'h1;
      end
    end
  end

endmodule

// ---- verification/sar_adc_checker.sv ----
// port assertions for the converter control block
// assumes it is bound to sar_adc_control with hready tied to hreadyout
`timescale 1ns/1ps
module sar_adc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sar_sample,
  input wire logic sar_enable,
  input wire logic sar_power_down,
  input wire logic [4:0] sar_channel,
  input wire logic temp_sensor_enable
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  sequence rd_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_taken;
    hsel && hready && htrans[1] && hwrite;
  endsequence

  chk_resp_always_okay: assert property (hresp == 1'b0)
    else $error("bus error response seen");
  chk_read_one_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  chk_write_no_wait: assert property (wr_taken |=> hreadyout)
    else $error("write data phase stalled");

  // ----------------------------------------------------------------
  // converter side
  // ----------------------------------------------------------------
  chk_off_means_chan: assert property (sar_power_down == (sar_channel == adc_ctrl_pkg::CHAN_DISABLED))
    else $error("power down does not follow channel field");
  chk_off_stays_idle: assert property (sar_power_down [*3] |-> !sar_enable && !sar_sample)
    else $error("converter busy while switched off");
  chk_temp_route: assert property (temp_sensor_enable |-> sar_enable && sar_channel == adc_ctrl_pkg::CHAN_TEMP)
    else $error("sensor routed on wrong channel");
  chk_sample_min_len: assert property ($fell(sar_sample) && sar_enable |-> $past(sar_sample, 4))
    else $error("sample phase shorter than four ticks");
  chk_sample_while_busy: assert property (sar_sample |-> sar_enable)
    else $error("sampling while converter idle");
endmodule

// ---- verification/sar_analog_model.sv ----
// behavioural analog side: comparator of a fixed input level against the trial code
// assumes trial code and enable come from the control block in the hclk domain
`timescale 1ns/1ps
module sar_analog_model (
  input wire logic hclk,
  input wire logic sar_enable,
  input wire logic [11:0] sar_dac_code,
  input wire logic [11:0] input_level,
  output logic sar_compare_in
);
  initial sar_compare_in = 1'b0;
  // an idle converter answers nothing useful, so the line wanders rather than holding
  always @(posedge hclk) begin
    if (sar_enable) begin
      sar_compare_in <= (input_level >= sar_dac_code);
    end else begin
      sar_compare_in <= ~sar_compare_in;
    end
  end
endmodule

// ---- verification/tb.sv ----
// self-checking bench: ahb-lite register access and conversions against the analog model
// assumes the package, the control block, the model and the checker are compiled first
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] A1 = adc_ctrl_pkg::ADDR_CONV_ONE;
  localparam logic [7:0] A2 = adc_ctrl_pkg::ADDR_CONV_TWO;
  localparam logic [7:0] AR = adc_ctrl_pkg::ADDR_RESULT;
  localparam logic [7:0] AV = adc_ctrl_pkg::ADDR_COMPARE;
  localparam logic [7:0] AC = adc_ctrl_pkg::ADDR_CONFIG;
  localparam logic [7:0] AP = adc_ctrl_pkg::ADDR_PIN_CTRL;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, async_clk, alt_clk, cmp;
  logic sar_sample, sar_enable, pdn, low_pow, temp_en, conv_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] rtc_cnt, rtc_mod;
  logic [11:0] dac, level;
  logic [4:0] chan;
  logic [15:0] pin_en;
  logic [1:0] modes [3] = '{adc_ctrl_pkg::MODE_12, adc_ctrl_pkg::MODE_10, adc_ctrl_pkg::MODE_8};
  // the bandgap buffer is taken as enabled outside the block before its code is used
  logic [4:0] chs [6] = '{5'h1a, 5'h15, 5'h1c, 5'h1b, 5'h1e, 5'h0f};
  int failures, num_checks, cycles;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  always #20 async_clk = ~async_clk;
  always #33 alt_clk = ~alt_clk;

  sar_adc_control u_sar_adc_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rtc_counter_value(rtc_cnt), .rtc_modulo_value(rtc_mod),
    .local_async_clock(async_clk), .alternate_clock_input(alt_clk), .sar_compare_in(cmp),
    .sar_dac_code(dac), .sar_sample(sar_sample), .sar_enable(sar_enable), .sar_power_down(pdn),
    .sar_low_power(low_pow), .sar_channel(chan), .temp_sensor_enable(temp_en),
    .analog_pin_enable(pin_en), .conv_irq(conv_irq));
  sar_analog_model u_sar_analog_model (.hclk(hclk), .sar_enable(sar_enable), .sar_dac_code(dac),
    .input_level(level), .sar_compare_in(cmp));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready is sampled at the rising edge, before the slave's own update of that edge lands;
  // only the bench timeout ends a wait
  task automatic wait_rdy();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    do begin
      bus(1'b0, a, 32'h0);
    end while (rd[b] !== v);
  endtask
  task automatic conv(input logic [7:0] cfg, input logic [4:0] ch, input logic [11:0] lv, input logic [31:0] res);
    level <= lv;
    bus(1'b1, AC, {24'h0, cfg});
    bus(1'b1, A1, {24'h0, 3'h2, ch});
    repeat (3) @(negedge hclk);
    chk(32'(temp_en), 32'(ch == adc_ctrl_pkg::CHAN_TEMP));
    @(posedge hclk);
    poll(A1, 7, 1'b1);
    chk(32'(conv_irq), 32'h1);
    rchk(AR, res);
    rchk(A1, {24'h0, 3'h2, ch});
    chk(32'(conv_irq), 32'h0);
    rchk(A2, 32'h0);
  endtask
  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // a hung handshake must still end in the verdict
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {hclk, hresetn, hsel, hwrite, async_clk, alt_clk} = 6'h0;
    {haddr, hwdata, htrans, rtc_cnt, level} = '0;
    rtc_mod = 8'h30;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(A1, 32'h1f);
    chk(32'(pdn), 32'h1);
    rchk(AC, 32'h0);
    rchk(8'h18, 32'h0);
    bus(1'b1, AP, 32'hffffffff);
    rchk(AP, 32'h0000ffff);
    chk(32'(pin_en), 32'hffff);
    for (int i = 0; i < 3; i++) begin
      conv({4'h0, modes[i], 2'h0}, 5'h03, 12'ha5c, 32'(12'ha5c >> (2 * i)));
    end
    // the bench stays in run mode: no stop3 entry, so no low-voltage bits and no alternate clock there
    for (int s = 0; s < 4; s++) begin
      conv({s == 1, 2'(s), s == 1, adc_ctrl_pkg::MODE_12, 2'(s)}, 5'h06, 12'h3c1, 32'h3c1);
      chk(32'(low_pow), 32'(s == 1));
    end
    for (int i = 0; i < 6; i++) begin
      conv(8'h04, chs[i], 12'h7e1, 32'h7e1);
    end
    bus(1'b1, AV, 32'h400);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, A2, i < 2 ? 32'h30 : 32'h20);
      level <= (i == 1 || i == 2) ? 12'h3ff : 12'h400;
      bus(1'b1, A1, 32'h03);
      poll(A2, 7, 1'b0);
      rchk(A1, i[0] ? 32'h03 : 32'h83);
    end
    bus(1'b1, A2, 32'h0);
    bus(1'b1, A1, 32'h23);
    poll(A1, 7, 1'b1);
    rchk(AR, 32'h400);
    poll(A1, 7, 1'b1);
    rchk(A2, 32'h80);
    bus(1'b1, A1, 32'h1f);
    repeat (40) @(posedge hclk);
    chk(32'(pdn), 32'h1);
    rchk(A2, 32'h0);
    rchk(A1, 32'h1f);
    bus(1'b1, A1, 32'h03);
    poll(A1, 7, 1'b1);
    bus(1'b1, A1, 32'h03);
    rchk(A1, 32'h03);
    rchk(A2, 32'h80);
    poll(A1, 7, 1'b1);
    bus(1'b1, A2, 32'h40);
    bus(1'b1, A1, 32'h05);
    repeat (30) @(posedge hclk);
    rchk(A2, 32'h40);
    rtc_cnt <= 8'h30;
    @(posedge hclk);
    rtc_cnt <= 8'h31;
    poll(A1, 7, 1'b1);
    rchk(A1, 32'h85);
    stop_test();
  end
endmodule

bind sar_adc_control sar_adc_checker u_sar_adc_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .sar_sample(sar_sample), .sar_enable(sar_enable), .sar_power_down(sar_power_down),
  .sar_channel(sar_channel), .temp_sensor_enable(temp_sensor_enable));
